// *** logic/ubg_top.sv ***
// Baud generator top: APB registers, transmit double buffer, shifter
`timescale 1ns/1ns
module ubg_top (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ubg_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Serial side
  output logic                            tx_serial,
  output logic                            bit_tick,
  output logic                            tx_buf_empty
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]             txcs_q;
  logic [7:0]             txcs_d;
  logic [7:0]             rxcs_q;
  logic [7:0]             rxcs_d;
  logic [7:0]             rate_q;
  logic [7:0]             rate_d;
  logic [7:0]             divl_q;
  logic [7:0]             divh_q;
  logic [7:0]             txbuf_q;
  logic                   ninth_buf_q;
  logic                   buf_full_q;
  logic                   buf_full_d;
  logic [10:0]            shift_q;
  logic [10:0]            shift_d;
  logic [3:0]             bits_q;
  logic [3:0]             bits_d;
  ubg_pkg::ubg_tx_state_t st_q;
  ubg_pkg::ubg_tx_state_t st_d;
  logic [31:0]            prdata_q;
  logic [7:0]             rd_w;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic acc;
  logic setup;
  logic sel_tx;
  logic sel_divl;
  logic sel_divh;
  logic sel_rxcs;
  logic sel_txcs;
  logic sel_rate;
  logic sel_rxd;
  logic hit;
  logic wr;
  logic wr_tx;
  logic wr_divl;
  logic wr_divh;
  logic wr_rxcs;
  logic wr_txcs;
  logic wr_rate;

  assign acc      = psel & penable;
  assign setup    = psel & ~penable;
  assign sel_tx   = (paddr == ubg_pkg::OFF_TX_DATA);
  assign sel_divl = (paddr == ubg_pkg::OFF_DIV_LO);
  assign sel_divh = (paddr == ubg_pkg::OFF_DIV_HI);
  assign sel_rxcs = (paddr == ubg_pkg::OFF_RX_CS);
  assign sel_txcs = (paddr == ubg_pkg::OFF_TX_CS);
  assign sel_rate = (paddr == ubg_pkg::OFF_RATE);
  assign sel_rxd  = (paddr == ubg_pkg::OFF_RX_DATA);
  assign hit      = sel_tx | sel_divl | sel_divh | sel_rxcs
                  | sel_txcs | sel_rate | sel_rxd;
  assign wr       = acc & pwrite & hit;
  assign wr_tx    = wr & sel_tx;
  assign wr_divl  = wr & sel_divl;
  assign wr_divh  = wr & sel_divh;
  assign wr_rxcs  = wr & sel_rxcs;
  assign wr_txcs  = wr & sel_txcs;
  assign wr_rate  = wr & sel_rate;

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Mode and control bits
  // ----------------------------------------------------------------
  logic sync_mode;
  logic wide_sel;
  logic high_speed;
  logic port_en;
  logic tx_en;
  logic nine_bit;
  logic shift_idle;

  assign sync_mode  = txcs_q[ubg_pkg::TXCS_SYNC];
  assign high_speed = txcs_q[ubg_pkg::TXCS_HIGH];
  assign wide_sel   = rate_q[ubg_pkg::RATE_WIDE];
  assign port_en    = rxcs_q[ubg_pkg::RXCS_SPEN];
  assign tx_en      = txcs_q[ubg_pkg::TXCS_TXEN];
  assign nine_bit   = txcs_q[ubg_pkg::TXCS_NINE];
  assign shift_idle = (st_q == ubg_pkg::TX_IDLE);

  // Status bit is hardware state, so it is merged on read, not stored
  assign txcs_d = wr_txcs ? (pwdata[7:0] & ubg_pkg::TXCS_WMASK) : txcs_q;
  assign rxcs_d = wr_rxcs ? (pwdata[7:0] & ubg_pkg::RXCS_WMASK) : rxcs_q;
  assign rate_d = wr_rate ? (pwdata[7:0] & ubg_pkg::RATE_WMASK) : rate_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_w = ubg_pkg::RST_BYTE;
    if (sel_tx) begin
      rd_w = txbuf_q;
    end else if (sel_divl) begin
      rd_w = divl_q;
    end else if (sel_divh) begin
      rd_w = divh_q;
    end else if (sel_rxcs) begin
      rd_w = rxcs_q;
    end else if (sel_txcs) begin
      rd_w = txcs_q | {6'h00, shift_idle, 1'b0};
    end else if (sel_rate) begin
      rd_w = rate_q | ubg_pkg::RATE_RO_SET;
    end else begin
      rd_w = ubg_pkg::RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcs_q <= ubg_pkg::RST_BYTE;
      rxcs_q <= ubg_pkg::RST_BYTE;
      rate_q <= ubg_pkg::RST_BYTE;
    end else begin
      txcs_q <= txcs_d;
      rxcs_q <= rxcs_d;
      rate_q <= rate_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divl_q <= ubg_pkg::RST_BYTE;
    end else if (wr_divl) begin
      divl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divh_q <= ubg_pkg::RST_BYTE;
    end else if (wr_divh) begin
      divh_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_w};
    end
  end

  // ----------------------------------------------------------------
  // Baud rate counter
  // ----------------------------------------------------------------
  logic restart;

  // A disabled port holds the counter at zero
  assign restart = wr_divl | wr_divh | ~port_en;

  ubg_rate_div u_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .restart    (restart),
    .sync_mode  (sync_mode),
    .wide_sel   (wide_sel),
    .high_speed (high_speed),
    .div_low    (divl_q),
    .div_high   (divh_q),
    .bit_tick   (bit_tick)
  );

  // ----------------------------------------------------------------
  // Transmit double buffer
  // ----------------------------------------------------------------
  logic tx_take;
  logic tx_load;
  logic [10:0] frame_w;

  // A write into a full buffer is dropped; software polls first
  assign tx_take = wr_tx & ~buf_full_q;
  // Buffer frees as soon as its value moves into the shifter
  assign tx_load = shift_idle & buf_full_q & tx_en & port_en;
  assign buf_full_d = tx_take | (buf_full_q & ~tx_load);
  assign tx_buf_empty = ~buf_full_q;

  // Stop, ninth or second stop, data LSB first, start
  assign frame_w = nine_bit ? {1'b1, ninth_buf_q, txbuf_q, 1'b0}
                            : {2'b11, txbuf_q, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf_q     <= ubg_pkg::RST_BYTE;
      ninth_buf_q <= 1'b0;
    end else if (tx_take) begin
      txbuf_q     <= pwdata[7:0];
      ninth_buf_q <= txcs_q[ubg_pkg::TXCS_NINTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_full_q <= 1'b0;
    end else begin
      buf_full_q <= buf_full_d;
    end
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    shift_d = shift_q;
    bits_d  = bits_q;
    case (st_q)
      ubg_pkg::TX_IDLE: begin
        if (tx_load) begin
          st_d    = ubg_pkg::TX_SHIFT;
          shift_d = frame_w;
          bits_d  = nine_bit ? ubg_pkg::FRAME_9 : ubg_pkg::FRAME_8;
        end
      end
      ubg_pkg::TX_SHIFT: begin
        if (bit_tick) begin
          shift_d = {1'b1, shift_q[10:1]};
          bits_d  = bits_q - 4'h1;
          if (bits_q == 4'h1) begin
            st_d = ubg_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        st_d    = ubg_pkg::TX_IDLE;
        shift_d = ubg_pkg::SHIFT_IDLE;
        bits_d  = 4'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ubg_pkg::TX_IDLE;
      shift_q <= ubg_pkg::SHIFT_IDLE;
      bits_q  <= 4'h0;
    end else begin
      st_q    <= st_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
    end
  end

  // Idle line is high because the shifter refills with ones
  assign tx_serial = shift_q[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_take: assert property (tx_take |=> buf_full_q
    && txbuf_q == $past(pwdata[7:0]))
    else $error("transmit write not buffered");

  a_buf_handoff: assert property (tx_load |=> st_q == ubg_pkg::TX_SHIFT
    && !buf_full_q && shift_q[8:1] == $past(txbuf_q) && !shift_q[0])
    else $error("buffer not handed to shifter");

  a_full_refuse: assert property (wr_tx && buf_full_q |=> txbuf_q == $past(txbuf_q))
    else $error("full buffer overwritten");

  a_low_write: assert property (wr_divl |=> divl_q == $past(pwdata[7:0])
    && !bit_tick ##1 !bit_tick [*2])
    else $error("low divisor write did not restart counter");

  a_high_write: assert property (wr_divh |=> divh_q == $past(pwdata[7:0])
    && !bit_tick ##1 !bit_tick [*2])
    else $error("high divisor write did not restart counter");

  a_mode_bits: assert property (wr_txcs |=> sync_mode ==
    $past(pwdata[ubg_pkg::TXCS_SYNC]) && high_speed == $past(pwdata[ubg_pkg::TXCS_HIGH]))
    else $error("mode select bit not applied");

  a_wide_bit: assert property (wr_rate |=> wide_sel == $past(pwdata[ubg_pkg::RATE_WIDE]))
    else $error("wide divisor bit not applied");

  // ----------------------------------------------------------------
  // Buffer, line and refusal checks
  // ----------------------------------------------------------------
  a_ninth_capture: assert property (tx_take |=>
    ninth_buf_q == $past(txcs_q[ubg_pkg::TXCS_NINTH]))
    else $error("ninth bit not buffered");

  // A stuck low line between frames would look like a start bit
  a_idle_high: assert property (st_q == ubg_pkg::TX_IDLE |-> tx_serial)
    else $error("idle line not high");

  a_shift_step: assert property (st_q == ubg_pkg::TX_SHIFT && bit_tick |=>
    tx_serial == $past(shift_q[1]))
    else $error("line did not advance on tick");

  a_frame_end: assert property (st_q == ubg_pkg::TX_SHIFT && bit_tick
    && bits_q == 4'h1 |=> st_q == ubg_pkg::TX_IDLE)
    else $error("frame did not end after last bit");

  a_unmapped_quiet: assert property (acc && !hit |=> txcs_q == $past(txcs_q)
    && rate_q == $past(rate_q) && divl_q == $past(divl_q) && divh_q == $past(divh_q))
    else $error("unmapped access changed a register");

  c_back_to_back: cover property (tx_load ##1 tx_take);
  c_frame_done:   cover property (st_q == ubg_pkg::TX_SHIFT ##1 st_q == ubg_pkg::TX_IDLE);
  c_div_restart:  cover property (port_en && wr_divh);

endmodule

// *** logic/ubg_pkg.sv ***
// Constants and register map for the baud generator block
//
// Function
// - Transmit data and ninth bit double buffered
// - Low divisor write stores byte, restarts counter
// - High divisor write stores byte, restarts counter
// - High byte ignored unless wide divisor selected
// - Divisor is high byte over low byte
// - Async, 8-bit, low speed: clock/(64(n+1))
// - Async, 16-bit, low speed: clock/(16(n+1))
// - Sync, 8-bit: clock/(4(n+1)), speed ignored
// - Mode bit set means sync; wide bit 16-bit
package ubg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_TX_DATA = 8'h00;
  localparam logic [7:0] OFF_DIV_LO  = 8'h04;
  localparam logic [7:0] OFF_DIV_HI  = 8'h08;
  localparam logic [7:0] OFF_RX_CS   = 8'h0C;
  localparam logic [7:0] OFF_TX_CS   = 8'h10;
  localparam logic [7:0] OFF_RATE    = 8'h14;
  localparam logic [7:0] OFF_RX_DATA = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TXCS_NINTH = 0;
  localparam int unsigned TXCS_TRMT  = 1;
  localparam int unsigned TXCS_HIGH  = 2;
  localparam int unsigned TXCS_SYNC  = 4;
  localparam int unsigned TXCS_TXEN  = 5;
  localparam int unsigned TXCS_NINE  = 6;
  localparam int unsigned RXCS_SPEN  = 7;
  localparam int unsigned RATE_WIDE  = 3;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] TXCS_WMASK  = 8'hFD;
  localparam logic [7:0] RXCS_WMASK  = 8'hF8;
  localparam logic [7:0] RATE_WMASK  = 8'h1B;
  localparam logic [7:0] RATE_RO_SET = 8'h40;
  localparam logic [10:0] SHIFT_IDLE = 11'h7FF;

  // ----------------------------------------------------------------
  // Rate factors and frame lengths
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W  = 16;
  localparam int unsigned PER_W  = 23;
  localparam logic [6:0] FACT_4  = 7'h04;
  localparam logic [6:0] FACT_16 = 7'h10;
  localparam logic [6:0] FACT_64 = 7'h40;
  localparam logic [3:0] FRAME_8 = 4'hA;
  localparam logic [3:0] FRAME_9 = 4'hB;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } ubg_tx_state_t;

endpackage

// *** logic/ubg_rate_div.sv ***
// Baud rate counter: prescaler by mode factor, then divide by n+1
`timescale 1ns/1ns
module ubg_rate_div (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       restart,
  input  wire logic       sync_mode,
  input  wire logic       wide_sel,
  input  wire logic       high_speed,
  input  wire logic [7:0] div_low,
  input  wire logic [7:0] div_high,
  // Output
  output logic            bit_tick
);

  logic [ubg_pkg::DIV_W-1:0] n_eff;
  logic [6:0]                factor;
  logic                      pre_last;
  logic [5:0]                pre_q;
  logic [5:0]                pre_d;
  logic [ubg_pkg::DIV_W-1:0] cnt_q;
  logic [ubg_pkg::DIV_W-1:0] cnt_d;

  // High byte only counts in the wide generator
  assign n_eff = wide_sel ? {div_high, div_low} : {8'h00, div_low};

  assign factor = sync_mode               ? ubg_pkg::FACT_4 :
                  (wide_sel & high_speed) ? ubg_pkg::FACT_4 :
                  (wide_sel | high_speed) ? ubg_pkg::FACT_16 :
                                            ubg_pkg::FACT_64;

  // Compare with >= so a mode change mid-count cannot run past the end
  assign pre_last = ({1'b0, pre_q} >= (factor - 7'h01));
  assign bit_tick = pre_last & (cnt_q >= n_eff) & ~restart;
  assign pre_d    = (restart | pre_last) ? 6'h00 : pre_q + 6'h01;
  assign cnt_d    = (restart | bit_tick) ? 16'h0000 :
                    pre_last ? cnt_q + 16'h0001 : cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
      cnt_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [ubg_pkg::PER_W-1:0] per_q;
  logic                      chk_q;
  logic                      chk_w;
  logic [2:0]                cfg_q;
  logic [2:0]                cfg_w;
  logic [ubg_pkg::PER_W-1:0] per_w;
  logic [ubg_pkg::PER_W-1:0] np1_w;

  assign cfg_w = {sync_mode, wide_sel, high_speed};
  assign per_w = per_q + 23'h00_0001;
  assign np1_w = 23'(n_eff) + 23'h00_0001;
  // A tick in the very cycle that a mode bit changes belongs to the old mode
  assign chk_w = chk_q & (cfg_w == cfg_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q <= 23'h00_0000;
      chk_q <= 1'b1;
      cfg_q <= 3'h0;
    end else begin
      per_q <= (restart | bit_tick) ? 23'h00_0000 : per_w;
      chk_q <= restart ? 1'b1 : (cfg_w != cfg_q) ? 1'b0 : bit_tick ? 1'b1 : chk_q;
      cfg_q <= cfg_w;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_high_ignored: assert property (!wide_sel |-> n_eff == 16'(div_low))
    else $error("high divisor byte used in narrow mode");
  a_divisor_concat: assert property (wide_sel |-> n_eff == {div_high, div_low})
    else $error("divisor not high over low");
  a_async_low_rate: assert property (bit_tick && chk_w && !sync_mode && !wide_sel && !high_speed
    |-> per_w == 23'(ubg_pkg::FACT_64) * np1_w)
    else $error("async 8-bit low speed period wrong");
  a_async_wide_rate: assert property (bit_tick && chk_w && !sync_mode && wide_sel && !high_speed
    |-> per_w == 23'(ubg_pkg::FACT_16) * np1_w)
    else $error("async 16-bit low speed period wrong");
  a_sync_narrow_rate: assert property (bit_tick && chk_w && sync_mode && !wide_sel
    |-> per_w == 23'(ubg_pkg::FACT_4) * np1_w)
    else $error("sync 8-bit period wrong");
  a_other_rates: assert property (bit_tick && chk_w && (wide_sel && (sync_mode || high_speed)
    || !sync_mode && !wide_sel && high_speed)
    |-> per_w == 23'(high_speed && !wide_sel ? ubg_pkg::FACT_16 : ubg_pkg::FACT_4) * np1_w)
    else $error("remaining mode period wrong");

  c_async_tick: cover property (bit_tick && chk_w && !sync_mode && !high_speed);
  c_sync_tick:  cover property (bit_tick && chk_w && sync_mode);

endmodule

// *** dv/ubg_line_rx.sv ***
// Far-side line receiver model that deframes the serial transmit line
`timescale 1ns/1ns
module ubg_line_rx (
  // Line side
  input  wire logic       pclk,
  input  wire logic       bit_tick,
  input  wire logic       tx_serial,
  input  wire logic       nine,
  // Results
  output logic      [8:0] last,
  output int              n,
  output logic            bad
);
  logic [10:0] bits;
  int          idx;
  logic        busy;

  initial begin
    n = 0;
    bad = 1'b0;
    busy = 1'b0;
    idx = 0;
    bits = '0;
    last = '0;
  end

  // Sampled on the falling edge so the tick and the line are both settled;
  // a bit is taken at the tick that ends it, so a short first bit still counts
  always @(negedge pclk) begin
    if (!busy && tx_serial === 1'b0) begin
      busy = 1'b1;
      idx = 0;
    end
    if (busy && bit_tick === 1'b1) begin
      bits[idx] = tx_serial;
      idx++;
      if (idx == (nine ? 11 : 10)) begin
        busy = 1'b0;
        last = {nine ? bits[9] : 1'b0, bits[8:1]};
        if (bits[0] !== 1'b0 || bits[idx-1] !== 1'b1) begin
          bad = 1'b1;
        end
        n++;
      end
    end
  end
endmodule

// *** dv/tb_uart_baud_generator.sv ***
// Self-checking bench for the baud generator top
`timescale 1ns/1ns
module tb_uart_baud_generator;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_serial;
  logic        bit_tick;
  logic        tx_buf_empty;
  logic        nine;
  logic [8:0]  rx_last;
  int          rx_n;
  logic        rx_bad;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;

  ubg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_serial(tx_serial), .bit_tick(bit_tick),
    .tx_buf_empty(tx_buf_empty));

  ubg_line_rx u_line (.pclk(pclk), .bit_tick(bit_tick), .tx_serial(tx_serial),
    .nine(nine), .last(rx_last), .n(rx_n), .bad(rx_bad));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Counts falling edges up to and including the one that sees a tick
  task automatic tick_wait(output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (bit_tick !== 1'b1 && c < 5000);
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    chk("tx_serial idle", 32'h0000_0001, 32'(tx_serial));
    chk("tx_buf_empty", 32'h0000_0001, 32'(tx_buf_empty));
    rdchk("tx data reset", 8'h00, 32'h0000_0000);
    rdchk("div low reset", 8'h04, 32'h0000_0000);
    rdchk("div high reset", 8'h08, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(err));
    chk("unmapped read", 32'h0000_0000, rd);
    rdchk("tx status reset", 8'h10, 32'h0000_0002);
    rdchk("rate reset", 8'h14, 32'h0000_0040);
    rdchk("rx data reset", 8'h18, 32'h0000_0000);
    wr(8'h0C, 8'hFF);
    rdchk("rx control mask", 8'h0C, 32'h0000_00F8);
    $display("test reset done");
  endtask

  task automatic t_rate(input string nm, input logic [7:0] tcs, input logic [7:0] rate,
                        input logic [7:0] lo, input logic [7:0] hi, input int p);
    int c;
    wr(8'h10, tcs);
    wr(8'h14, rate);
    wr(8'h04, lo);
    wr(8'h08, hi);
    tick_wait(c);
    chk({nm, " after high write"}, p, c);
    tick_wait(c);
    chk({nm, " period"}, p, c);
    repeat (3) @(negedge pclk);
    wr(8'h04, lo);
    tick_wait(c);
    chk({nm, " after low write"}, p, c);
    rdchk("div low", 8'h04, {24'h00_0000, lo});
    rdchk("div high", 8'h08, {24'h00_0000, hi});
    $display("test rate %s done", nm);
  endtask

  task automatic t_tx;
    int i;
    nine = 1'b1;
    wr(8'h14, 8'h08);
    wr(8'h10, 8'h65);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'hA5);
    @(negedge pclk);
    chk("buffer full", 32'h0000_0000, 32'(tx_buf_empty));
    for (i = 0; i < 50 && tx_buf_empty !== 1'b1; i++) @(negedge pclk);
    chk("first frame busy", 32'h0000_0000, rx_n);
    wr(8'h10, 8'h64);
    wr(8'h00, 8'h3C);
    wr(8'h00, 8'hFF);
    for (i = 0; i < 300 && rx_n < 1; i++) @(negedge pclk);
    chk("frame one", 32'h0000_01A5, 32'(rx_last));
    for (i = 0; i < 300 && rx_n < 2; i++) @(negedge pclk);
    chk("frame two", 32'h0000_003C, 32'(rx_last));
    repeat (100) @(negedge pclk);
    chk("frame count", 32'h0000_0002, rx_n);
    chk("line framing", 32'h0000_0000, 32'(rx_bad));
    rdchk("shifter idle", 8'h10, 32'h0000_0066);
    rdchk("tx data kept", 8'h00, 32'h0000_003C);
    rdchk("rate mask", 8'h14, 32'h0000_0048);
    $display("test transmit done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang anywhere ends the run here
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      $display("timeout after %0d cycles", cycles);
      summarize;
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    nine = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rate("async slow 8", 8'h20, 8'h00, 8'h03, 8'h05, 256);
    t_rate("async slow 16", 8'h20, 8'h08, 8'h02, 8'h01, 4144);
    t_rate("sync 8", 8'h34, 8'h00, 8'h09, 8'h07, 40);
    t_rate("async fast 8", 8'h24, 8'h00, 8'h05, 8'h01, 96);
    t_rate("async fast 16", 8'h24, 8'h08, 8'h00, 8'h02, 2052);
    t_rate("sync 16", 8'h30, 8'h08, 8'h03, 8'h00, 16);
    t_tx;
    summarize;
  end
endmodule
